// ### rtl/reset_source_and_supply_monitor.sv
// reset sequencer and supply integrity monitor with a one-register wishbone slave
// assumes clk at 50 MHz, option inputs static while running, pull-up on the reset pin
//
// Function
// (RULE1) reset pin is open-drain: input, low-only output, enable; others may pull it low
// (RULE2) low on the reset pin forces core reset without any clock edge; the code ignores the pin during the two vector fetch cycles
// (RULE3) pin driven low for as long as the low-voltage reset is asserted
// (RULE4) watchdog underflow drives the pin low at least the minimum pulse width
// (RULE5) low-voltage detector enabled only by the option input, never by software
// (RULE6) auxiliary detector, its flag and interrupt idle when low-voltage option is off
// (RULE7) bit 5 shows the live auxiliary comparator, read only, 1 means low supply
// (RULE8) with bit 6 set every toggle of the auxiliary flag pends an interrupt
// (RULE9) pending auxiliary interrupt cleared when its service routine is entered
// (RULE10) crossings during the reset delay raise no auxiliary interrupt
// (RULE11) enabling before a slow rise crossing gives two interrupts
// (RULE12) enabling after the slow rise crossing gives exactly one interrupt; the code gives none, as the flag already reads normal
// (RULE13) wait mode keeps monitoring, pending interrupt wakes from wait
// (RULE14) halt mode freezes the register, no wake from halt
// (RULE15) bit 4 set by low-voltage reset, cleared by writing zero
// (RULE16) bit 0 set by watchdog reset, cleared by low-voltage reset or writing zero
// (RULE17) flags encode the last source: none external, bit 0 watchdog, bit 4 low voltage
// (RULE18) software writes zero to reserved bits 7 and 3 to 1
// (RULE19) after release pin stays low 256 or 4096 cycles, then two fetch cycles
// (RULE20) external or watchdog reset keeps bit 4 set
// (RULE21) pin and comparator levels synchronised before flags or toggle logic use them
// (RULE22) enabling the interrupt while the flag shows low supply pends at once
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rsm_consts.svh"

module reset_source_and_supply_monitor #(
   parameter logic [12:0] DELAY_SHORT = 13'(`RSM_DELAY_SHORT_CYC),
   parameter logic [12:0] DELAY_LONG = 13'(`RSM_DELAY_LONG_CYC),
   parameter logic [12:0] WDOG_PULSE = 13'(`RSM_WDOG_PULSE_CYC)
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst_n,
   // register bus
   input wire rsm_pkg::wb_req_t wb_i,
   output rsm_pkg::wb_rsp_t wb_o,
   // open-drain reset pin
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe,
   // option settings
   input wire logic lowvolt_option_en,
   input wire logic long_delay_option,
   // analog comparator levels
   input wire logic lowvolt_cmp_async,
   input wire logic aux_cmp_async,
   // cpu side events and modes
   input wire logic wdog_underflow,
   input wire logic irq_ack,
   input wire logic wait_mode,
   input wire logic halt_mode,
   // to the core
   output logic core_reset_n,
   output logic vector_fetch,
   output logic aux_irq,
   output logic wait_wake
);

   ////////////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      rsm_pkg::seq_state_t st;
      rsm_pkg::reset_src_t src;
      logic [12:0] cnt;
      logic irq_en;
      logic aux_flag;
      logic lowvolt_flag;
      logic wdog_flag;
      logic pending;
      logic ack;
      logic [7:0] rdat;
   } core_state_t;

   core_state_t cur_reg;
   core_state_t cur_next;

   logic pin_ok;
   logic lowvolt_sync;
   logic aux_sync;
   logic pin_arst_n;
   logic lowvolt_act;
   logic aux_live;
   logic in_run;
   logic req, hit, wr_hit;
   logic en_rise, pend_set;
   logic [7:0] csr_byte;
   logic [12:0] delay_load;

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers

   // pin low clears the pin sync at once, so reset reaches the core even with clk stopped
   assign pin_arst_n = rst_n & rst_pin_i; // [RULE2]

   sync2 #(.RESET_VAL(1'b0)) u_pin_sync (
      .clk(clk),
      .arst_n(pin_arst_n),
      .d_async(1'b1),
      .q(pin_ok)
   ); // [RULE21]

   sync2 #(.RESET_VAL(1'b0)) u_lowvolt_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d_async(lowvolt_cmp_async),
      .q(lowvolt_sync)
   ); // [RULE21]

   sync2 #(.RESET_VAL(1'b0)) u_aux_sync (
      .clk(clk),
      .arst_n(rst_n),
      .d_async(aux_cmp_async),
      .q(aux_sync)
   ); // [RULE21]

   ////////////////////////////////////////////////////////////////////////////////
   // source qualification and register view

   // detector gating comes only from the option input, no register bit reaches it
   assign lowvolt_act = lowvolt_option_en & lowvolt_sync; // [RULE5]
   assign aux_live = lowvolt_option_en & aux_sync; // [RULE6]
   assign in_run = (cur_reg.st == rsm_pkg::ST_RUN);

   // reserved bits read as zero
   always_comb
   begin
      csr_byte = `RSM_CSR_RESET;
      csr_byte[`RSM_BIT_AUX_IRQ_EN] = cur_reg.irq_en;
      csr_byte[`RSM_BIT_AUX_FLAG] = cur_reg.aux_flag; // [RULE7]
      csr_byte[`RSM_BIT_LOWVOLT_FLAG] = cur_reg.lowvolt_flag; // [RULE17]
      csr_byte[`RSM_BIT_WDOG_FLAG] = cur_reg.wdog_flag; // [RULE17]
   end

   // bus decode; a second cycle of the same strobe is not taken while ack is up
   assign req = wb_i.cyc & wb_i.stb & ~cur_reg.ack;
   assign hit = (wb_i.adr == `RSM_CSR_OFFSET);
   assign wr_hit = req & wb_i.we & hit & wb_i.sel[0] & ~halt_mode; // [RULE14]
   assign en_rise = wr_hit & wb_i.dat[`RSM_BIT_AUX_IRQ_EN] & ~cur_reg.irq_en;
   assign delay_load = long_delay_option ? (DELAY_LONG - 13'h0001) : (DELAY_SHORT - 13'h0001); // [RULE19]

   // toggle of the flag, or enabling while the supply already reads low
   assign pend_set = (cur_reg.irq_en & (aux_live != cur_reg.aux_flag)) | (en_rise & aux_live); // [RULE8] [RULE22]

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      cur_next = cur_reg;

      // bus answer one cycle after the request, dropped in the following cycle
      cur_next.ack = req;
      cur_next.rdat = req ? (hit ? csr_byte : 8'h00) : cur_reg.rdat;

      // software side of the register; reserved write bits are dropped
      if (wr_hit)
      begin
         cur_next.irq_en = wb_i.dat[`RSM_BIT_AUX_IRQ_EN]; // [RULE18]
         cur_next.lowvolt_flag = cur_reg.lowvolt_flag & wb_i.dat[`RSM_BIT_LOWVOLT_FLAG]; // [RULE15] one keeps
         cur_next.wdog_flag = cur_reg.wdog_flag & wb_i.dat[`RSM_BIT_WDOG_FLAG]; // [RULE16] zero clears
      end

      // auxiliary monitor, frozen in halt, running normally in wait
      if (!halt_mode)
      begin
         cur_next.aux_flag = aux_live; // [RULE7] [RULE13]
         cur_next.pending = cur_reg.pending & ~irq_ack; // [RULE9]
         if (pend_set && in_run)
         begin
            cur_next.pending = 1'b1; // [RULE8] [RULE11] [RULE12]
         end
      end
      cur_next.pending = cur_next.pending & lowvolt_option_en; // [RULE6]

      // sequencer; low voltage outranks every other source in every phase
      if (lowvolt_act)
      begin
         cur_next.st = rsm_pkg::ST_ACTIVE; // [RULE3]
         cur_next.src = rsm_pkg::SRC_LOWVOLT;
         cur_next.lowvolt_flag = 1'b1; // [RULE15]
         cur_next.wdog_flag = 1'b0; // [RULE16]
      end
      else
      begin
         case (cur_reg.st)
            rsm_pkg::ST_ACTIVE:
            begin
               case (cur_reg.src)
                  rsm_pkg::SRC_WDOG:
                  begin
                     if (cur_reg.cnt != 13'h0000)
                     begin
                        cur_next.cnt = cur_reg.cnt - 13'h0001; // [RULE4]
                     end
                     else
                     begin
                        cur_next.st = rsm_pkg::ST_DELAY;
                        cur_next.cnt = delay_load;
                     end
                  end
                  rsm_pkg::SRC_EXT:
                  begin
                     // wait for the outside party to let go of the pin
                     if (pin_ok)
                     begin
                        cur_next.st = rsm_pkg::ST_DELAY;
                        cur_next.cnt = delay_load;
                     end
                  end
                  default:
                  begin
                     cur_next.st = rsm_pkg::ST_DELAY;
                     cur_next.cnt = delay_load;
                  end
               endcase
            end
            rsm_pkg::ST_DELAY:
            begin
               if (cur_reg.cnt == 13'h0000)
               begin
                  cur_next.st = rsm_pkg::ST_FETCH; // [RULE19]
                  cur_next.cnt = 13'(`RSM_FETCH_CYC - 1);
               end
               else
               begin
                  cur_next.cnt = cur_reg.cnt - 13'h0001;
               end
            end
            rsm_pkg::ST_FETCH:
            begin
               if (cur_reg.cnt == 13'h0000)
               begin
                  cur_next.st = rsm_pkg::ST_RUN;
               end
               else
               begin
                  cur_next.cnt = cur_reg.cnt - 13'h0001;
               end
            end
            rsm_pkg::ST_RUN:
            begin
               if (wdog_underflow)
               begin
                  cur_next.st = rsm_pkg::ST_ACTIVE;
                  cur_next.src = rsm_pkg::SRC_WDOG;
                  cur_next.cnt = WDOG_PULSE - 13'h0001; // [RULE4]
                  cur_next.wdog_flag = 1'b1; // [RULE16] [RULE20]
               end
               else if (!pin_ok)
               begin
                  cur_next.st = rsm_pkg::ST_ACTIVE; // [RULE20]
                  cur_next.src = rsm_pkg::SRC_EXT;
               end
            end
            default:
            begin
               cur_next.st = rsm_pkg::ST_ACTIVE;
            end
         endcase
      end

      // core in reset: enable and pending drop, flag keeps tracking so no stale toggle
      if (cur_next.st != rsm_pkg::ST_RUN)
      begin
         cur_next.irq_en = 1'b0; // [RULE10]
         cur_next.pending = 1'b0; // [RULE10]
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_reg <= '{st: rsm_pkg::ST_ACTIVE, src: rsm_pkg::SRC_POR, default: '0};
      end
      else
      begin
         cur_reg <= cur_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   // own drive stops while an external source holds the pin, else its release is unseen
   assign rst_pin_o = 1'b0; // [RULE1]
   assign rst_pin_oe = ((cur_reg.st == rsm_pkg::ST_ACTIVE) && (cur_reg.src != rsm_pkg::SRC_EXT))
                       || (cur_reg.st == rsm_pkg::ST_DELAY); // [RULE1] [RULE3] [RULE19]
   // fetch ignores the pin: its sync needs two cycles to see our own release
   assign core_reset_n = (cur_reg.st == rsm_pkg::ST_FETCH) || (in_run && pin_ok); // [RULE2]
   assign vector_fetch = (cur_reg.st == rsm_pkg::ST_FETCH); // [RULE19]
   assign aux_irq = cur_reg.pending;
   assign wait_wake = cur_reg.pending & wait_mode & ~halt_mode; // [RULE13] [RULE14]
   assign wb_o = '{ack: cur_reg.ack, dat: {24'h00_0000, cur_reg.rdat}};

   ////////////////////////////////////////////////////////////////////////////////
   // assertions

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   int unsigned dly_run;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dly_run <= 0;
      end
      else
      begin
         dly_run <= (cur_reg.st == rsm_pkg::ST_DELAY) ? dly_run + 1 : 0;
      end
   end

   sequence fetch_start;
      (cur_reg.st != rsm_pkg::ST_FETCH) ##1 (cur_reg.st == rsm_pkg::ST_FETCH);
   endsequence
   sequence fetch_two;
      vector_fetch ##1 vector_fetch ##1 (!vector_fetch && core_reset_n);
   endsequence

   AST_LOWVOLT_DRIVES_PIN: assert property (lowvolt_act |=> rst_pin_oe && !core_reset_n) // [RULE3]
      else $error("pin not driven during low-voltage reset");
   AST_WDOG_PULSE: assert property ((in_run && wdog_underflow) |=> rst_pin_oe [*8]) // [RULE4]
      else $error("watchdog pulse too short");
   AST_DELAY_LEN: assert property (fetch_start |-> (dly_run ==
      ($past(long_delay_option) ? int'(DELAY_LONG) : int'(DELAY_SHORT)))) // [RULE19]
      else $error("reset delay length wrong");
   AST_FETCH_TWO: assert property (fetch_start |-> fetch_two) // [RULE19]
      else $error("vector fetch not two cycles");
   AST_TOGGLE_PENDS: assert property ((in_run && cur_reg.irq_en && !halt_mode && lowvolt_option_en
      && (aux_live != cur_reg.aux_flag) && !lowvolt_act && !wdog_underflow && pin_ok) |=> aux_irq) // [RULE8]
      else $error("flag toggle did not pend");
   AST_ACK_CLEARS: assert property ((irq_ack && !pend_set && !halt_mode) |=> !aux_irq) // [RULE9]
      else $error("service entry did not clear pending");
   AST_HALT_FROZEN: assert property ((halt_mode && in_run) ##1 (halt_mode && in_run && !lowvolt_act)
      |-> $stable(csr_byte)) // [RULE14]
      else $error("register changed in halt");
   AST_AUX_IDLE: assert property ((!lowvolt_option_en && !halt_mode) |=> !cur_reg.aux_flag && !aux_irq) // [RULE6]
      else $error("aux detector active with option off");
   AST_ENABLE_LOW: assert property ((in_run && en_rise && aux_live && lowvolt_option_en
      && !lowvolt_act && !wdog_underflow && pin_ok) |=> aux_irq) // [RULE22]
      else $error("enable at low supply did not pend");
   AST_FLAGS: assert property (lowvolt_act |=> cur_reg.lowvolt_flag && !cur_reg.wdog_flag) // [RULE15]
      else $error("low-voltage flags wrong");
   AST_WDOG_FLAG: assert property ((in_run && wdog_underflow && !lowvolt_act && !wr_hit)
      |=> cur_reg.wdog_flag && $stable(cur_reg.lowvolt_flag)) // [RULE16]
      else $error("watchdog flag wrong");
   AST_WB_ACK: assert property ((wb_i.cyc && wb_i.stb && !wb_o.ack) |=> wb_o.ack ##1 !wb_o.ack)
      else $error("bus ack timing wrong");

endmodule // reset_source_and_supply_monitor

`default_nettype wire

// ### rtl/rsm_consts.svh
// reset sequencer and supply monitor constants: offsets, bit positions, reset values, timing
// assumes inclusion by its bare name from the sequencer design file
`ifndef RSM_CONSTS_SVH
`define RSM_CONSTS_SVH

// register map
`define RSM_CSR_OFFSET 8'h00
`define RSM_CSR_RESET 8'h00
`define RSM_BIT_WDOG_FLAG 0
`define RSM_BIT_LOWVOLT_FLAG 4
`define RSM_BIT_AUX_FLAG 5
`define RSM_BIT_AUX_IRQ_EN 6

// timing in cpu clock cycles and nanoseconds
`define RSM_CLK_PERIOD_NS 20
`define RSM_DELAY_SHORT_CYC 256
`define RSM_DELAY_LONG_CYC 4096
`define RSM_FETCH_CYC 2
`define RSM_WDOG_PULSE_NS 200
`define RSM_WDOG_PULSE_CYC ((`RSM_WDOG_PULSE_NS + `RSM_CLK_PERIOD_NS - 1) / `RSM_CLK_PERIOD_NS)

`endif

// ### rtl/rsm_pkg.sv
// types shared by the reset sequencer and its bench: states, sources, bus carriers
// assumes the classic wishbone slave uses an 8-bit byte address and 32-bit data
package rsm_pkg;

   // sequencer phases
   typedef enum logic [1:0] {ST_ACTIVE, ST_DELAY, ST_FETCH, ST_RUN} seq_state_t;

   // reset source that started the current sequence
   typedef enum logic [1:0] {SRC_POR, SRC_EXT, SRC_LOWVOLT, SRC_WDOG} reset_src_t;

   // wishbone request from the master
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_t;

   // wishbone answer from the slave
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;

endpackage

// ### rtl/sync2.sv
// two-flop level synchroniser with asynchronous reset to a constant
// assumes the reset input may itself be a gated asynchronous term
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // level crossing
   input wire logic d_async,
   output logic q
);

   logic meta_reg;
   logic q_reg;

   // first flop feeds only the second one
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_reg <= RESET_VAL;
         q_reg <= RESET_VAL;
      end
      else
      begin
         meta_reg <= d_async;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // sync2

`default_nettype wire

// ### dv/ext_reset_model.sv
// board side of the reset pin: pull-up resistor plus a switch that can pull it low
// assumes the design only ever pulls the pin low, through its output enable
`timescale 1ns/1ps
`default_nettype none

module ext_reset_model (
   // design side of the open-drain pin
   input wire logic pin_oe,
   input wire logic pin_o,
   // board switch, high pulls the line low
   input wire logic pull_low,
   output logic pin_level
);
   // wired-and: any enabled low driver wins, otherwise the pull-up gives high
   assign pin_level = ~((pin_oe & ~pin_o) | pull_low);
endmodule // ext_reset_model

`default_nettype wire

// ### dv/reset_source_and_supply_monitor_test.sv
// self-checking bench for the reset sequencer and supply monitor
// assumes short delay parameters and the board model driving the reset pin
`timescale 1ns/1ps
`default_nettype none

module reset_source_and_supply_monitor_test;
   localparam logic [12:0] DLY_S = 13'h0008;
   localparam logic [12:0] DLY_L = 13'h0010;
   localparam logic [12:0] PULSE = 13'h0003;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   rsm_pkg::wb_req_t wb_req = '0;
   rsm_pkg::wb_rsp_t wb_rsp;
   logic pin_level, pin_o, pin_oe, core_reset_n, vector_fetch, aux_irq, wait_wake;
   logic pull = 1'b0;
   logic lowvolt_en = 1'b1;
   logic long_dly = 1'b0;
   logic lowvolt_cmp = 1'b0;
   logic aux_cmp = 1'b1;
   logic wdog = 1'b0;
   logic irq_ack = 1'b0;
   logic wait_m = 1'b0;
   logic halt_m = 1'b0;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   int oe_n;
   logic [31:0] rd;

   ////////////////////////////////////////////////////////////////////////////
   // design, board model and clock
   reset_source_and_supply_monitor #(.DELAY_SHORT(DLY_S), .DELAY_LONG(DLY_L), .WDOG_PULSE(PULSE))
   i_reset_source_and_supply_monitor (
      .clk(clk), .rst_n(rst_n), .wb_i(wb_req), .wb_o(wb_rsp),
      .rst_pin_i(pin_level), .rst_pin_o(pin_o), .rst_pin_oe(pin_oe),
      .lowvolt_option_en(lowvolt_en), .long_delay_option(long_dly),
      .lowvolt_cmp_async(lowvolt_cmp), .aux_cmp_async(aux_cmp),
      .wdog_underflow(wdog), .irq_ack(irq_ack), .wait_mode(wait_m), .halt_mode(halt_m),
      .core_reset_n(core_reset_n), .vector_fetch(vector_fetch), .aux_irq(aux_irq), .wait_wake(wait_wake)
   );
   ext_reset_model i_ext_reset_model (.pin_oe(pin_oe), .pin_o(pin_o), .pull_low(pull), .pin_level(pin_level));

   // 50 MHz clock
   always #10 clk = ~clk;

   // hang guard, far above the few hundred cycles the scenarios need
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         miscompares++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // classic single cycle; entered just after a rising edge
   task automatic wb_io(input logic we, input logic [7:0] adr, input logic [7:0] wd);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h00_0000, wd}};
      // no local limit: only the bench timeout ends a wait for ack
      do
      begin
         @(posedge clk);
      end
      while (wb_rsp.ack !== 1'b1);
      rd = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk);
      // slave drops ack in the cycle after it gave it
      chk(wb_rsp.ack, 1'b0);
   endtask

   task automatic rd_chk(input logic [7:0] exp);
      wb_io(1'b0, 8'h00, 8'h00);
      chk(rd, {24'h00_0000, exp});
   endtask

   task automatic ack_irq();
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      idle(2);
   endtask

   // counts pin-enable and fetch cycles until the core runs again
   task automatic wait_run(output int oe_c);
      int f;
      f = 0;
      oe_c = 0;
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk);
         oe_c += int'(pin_oe === 1'b1);
         f += int'(vector_fetch === 1'b1);
         if (core_reset_n === 1'b1 && vector_fetch === 1'b0 && f > 0)
            break;
      end
      chk(32'(f), 32'h0000_0002);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_power_up();
      idle(2);
      rst_n <= 1'b1;
      // supply warning clears during the delay, must not count as a crossing
      fork
         wait_run(oe_n);
         begin
            idle(3);
            aux_cmp <= 1'b0;
         end
      join
      chk(32'(oe_n >= DLY_S), 32'h0000_0001);
      chk(aux_irq, 1'b0);
      rd_chk(8'h00);
   endtask

   task automatic t_regs();
      wb_io(1'b1, 8'h00, 8'h71);
      rd_chk(8'h40);
      wb_io(1'b1, 8'h04, 8'h00);
      chk(rd, 32'h0000_0000);
      rd_chk(8'h40);
   endtask

   task automatic t_aux_irq();
      aux_cmp <= 1'b1;
      idle(5);
      chk(aux_irq, 1'b1);
      rd_chk(8'h60);
      wait_m <= 1'b1;
      idle(1);
      chk(wait_wake, 1'b1);
      ack_irq();
      chk(aux_irq, 1'b0);
      aux_cmp <= 1'b0;
      idle(5);
      chk(aux_irq, 1'b1);
      ack_irq();
      // halt freezes register and blocks the wake
      aux_cmp <= 1'b1;
      idle(5);
      halt_m <= 1'b1;
      idle(1);
      chk(wait_wake, 1'b0);
      wb_io(1'b1, 8'h00, 8'h00);
      aux_cmp <= 1'b0;
      idle(5);
      rd_chk(8'h60);
      halt_m <= 1'b0;
      wait_m <= 1'b0;
      wb_io(1'b1, 8'h00, 8'h00);
      idle(5);
      ack_irq();
   endtask

   task automatic t_enable_low();
      aux_cmp <= 1'b1;
      idle(5);
      chk(aux_irq, 1'b0);
      wb_io(1'b1, 8'h00, 8'h40);
      chk(aux_irq, 1'b1);
      ack_irq();
      aux_cmp <= 1'b0;
      idle(5);
      chk(aux_irq, 1'b1);
      ack_irq();
      wb_io(1'b1, 8'h00, 8'h00);
      wb_io(1'b1, 8'h00, 8'h40);
      idle(2);
      chk(aux_irq, 1'b0);
   endtask

   task automatic t_resets();
      @(posedge clk);
      pull <= 1'b1;
      #1 chk(core_reset_n, 1'b0);
      idle(3);
      pull <= 1'b0;
      wait_run(oe_n);
      chk(32'(oe_n >= DLY_S), 32'h0000_0001);
      rd_chk(8'h00);
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      wait_run(oe_n);
      chk(32'(oe_n >= PULSE + DLY_S), 32'h0000_0001);
      rd_chk(8'h01);
      // long delay option on the low-voltage sequence
      long_dly <= 1'b1;
      lowvolt_cmp <= 1'b1;
      idle(5);
      chk(pin_level, 1'b0);
      idle(3);
      lowvolt_cmp <= 1'b0;
      wait_run(oe_n);
      // active phase lasts the two sync cycles plus the release edge, then the long delay
      chk(32'(oe_n >= DLY_L + 3), 32'h0000_0001);
      rd_chk(8'h10);
      long_dly <= 1'b0;
      wdog <= 1'b1;
      @(posedge clk);
      wdog <= 1'b0;
      wait_run(oe_n);
      rd_chk(8'h11);
      wb_io(1'b1, 8'h00, 8'h00);
      rd_chk(8'h00);
   endtask

   task automatic t_option_off();
      lowvolt_en <= 1'b0;
      aux_cmp <= 1'b1;
      lowvolt_cmp <= 1'b1;
      wb_io(1'b1, 8'h00, 8'h40);
      idle(6);
      chk(core_reset_n, 1'b1);
      chk(aux_irq, 1'b0);
      wb_io(1'b0, 8'h00, 8'h00);
      chk(rd & 32'h0000_0020, 32'h0000_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      t_power_up();
      t_regs();
      t_aux_irq();
      t_enable_low();
      t_resets();
      t_option_off();
      complete_run();
   end
endmodule // reset_source_and_supply_monitor_test

`default_nettype wire
